// [core/spp_pkg.sv]
// Package for the serial peripheral port: register map, fields, timing.
// Assumes APB with 32-bit data, 100 MHz pclk.
package spp_pkg;

  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STAT_OFS      = 8'h04;
  localparam logic [7:0]  TXBUF_OFS     = 8'h08;
  localparam logic [7:0]  RXBUF_OFS     = 8'h0c;
  localparam logic [7:0]  IRQ_STAT_OFS  = 8'h10;
  localparam logic [7:0]  IRQ_MASK_OFS  = 8'h14;
  localparam logic [7:0]  SLEEP_OFS     = 8'h18;

  // Control fields
  localparam int CTRL_ON_BIT     = 15;
  localparam int CTRL_MBUSY_BIT  = 11;
  localparam int CTRL_SHIFT_REG_EMPTY_FLAG_BIT   = 7;
  localparam int CTRL_SLAVE_BIT  = 5;
  localparam int CTRL_FRAME_BIT  = 31;
  localparam int CTRL_TXSEL_LSB  = 2;
  localparam int CTRL_FCNT_LSB   = 24;
  localparam logic [31:0] CTRL_RW_MASK  = 32'h8700_802c;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0080;

  // Status fields
  localparam int STAT_TUR_BIT    = 8;
  localparam int STAT_ROV_BIT    = 6;
  localparam int STAT_RBF_BIT    = 0;
  localparam int STAT_TBE_BIT    = 3;
  localparam logic [31:0] STAT_RESET    = 32'h0000_0008;

  // Interrupt status layout
  localparam int IRQ_TX_BIT      = 0;
  localparam int IRQ_RX_BIT      = 1;
  localparam int IRQ_TUR_BIT     = 2;
  localparam int IRQ_WAKE_BIT    = 3;
  localparam int IRQ_W           = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  localparam logic [1:0] TXSEL_UNDERRUN_BLIND = 2'b00;

  // Serial bit time in pclk cycles (125 ns link clock at 10 ns)
  localparam int PCLK_NS         = 10;
  localparam int BIT_NS          = 125;
  localparam int BIT_CYC         = BIT_NS / PCLK_NS;
  localparam int RECOVER_BITS    = 4;
  localparam logic [7:0] RECOVER_CYC = 8'(RECOVER_BITS * BIT_CYC);
  localparam logic [2:0] BITCNT_LAST = 3'h7;

  typedef struct packed {
    logic       sck;
    logic       frm;
    logic       sdi;
  } link_in_t;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_RECOVER} spp_state_t;

endpackage

// [core/spp_sync.sv]
// Two-stage synchroniser for link pins.
// Assumes asynchronous inputs; first stage read only by the second.
`timescale 1ns/1ps
module spp_sync
  import spp_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire link_in_t d,
  output link_in_t      q
);
  link_in_t meta_r;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
endmodule // spp_sync

// [core/spp_edge.sv]
// Rising and falling edge detector on a synchronised level.
// Assumes input is already in the pclk domain.
`timescale 1ns/1ps
module spp_edge
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic lvl,
  output logic      rise,
  output logic      fall
);
  logic prev_r;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prev_r <= 1'b0;
    else
      prev_r <= lvl;

  assign rise = lvl & ~prev_r;
  assign fall = ~lvl & prev_r;
endmodule // spp_edge

// [core/serial_peripheral_port.sv]
// Serial peripheral port slave/master-less core with APB registers.
// Assumes sck and frame pins come from an external party, asynchronous.
// Notes on behaviour
// [RL1] Slave mode, tx_irq_select 00: underrun does not raise transmit flag.
// [RL2] Software wanting underrun notice selects 01, 10 or 11.
// [RL3] Slave sleep entry after a transfer may raise a spurious wake interrupt.
// [RL4] Byte write to status byte 0 lands in bytes 0 and 1.
// [RL5] Byte write to status byte 1 is dropped.
// [RL6] Software uses only full-word access to the status register.
// [RL7] Framed: underrun flag clears before the engine is ready again.
// [RL8] Software waits four bit times after underrun clear before writes.
// [RL9] Busy flag clears and shift-empty flag sets half a bit time before the end.
// [RL10] Frame slave, count above zero: frame on clock edge corrupts data.
`timescale 1ns/1ps
module serial_peripheral_port
  import spp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck_in,
  input  wire logic        frm_in,
  input  wire logic        sdi_in,
  output logic             sdo_out,
  output logic             irq
);
  import spp_pkg::*;

  link_in_t   pin_raw;
  link_in_t   pin_s;
  logic       sck_rise;
  logic       sck_fall;
  logic       frm_rise;

  logic [31:0]      serial_port_control_reg;
  logic [31:0]      serial_port_status_reg;
  logic [31:0]      txbuf_r;
  logic [31:0]      rxbuf_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic             sleep_r;
  logic             sleep_prev_r;
  logic             xfer_done_r;
  spp_state_t       state_r;
  logic [7:0]       shift_r;
  logic [2:0]       bitcnt_r;
  logic [7:0]       rcv_r;
  logic [7:0]       wait_r;
  logic             tx_loaded_r;
  logic [IRQ_W-1:0] ev;

  assign pin_raw = '{sck: sck_in, frm: frm_in, sdi: sdi_in};

  spp_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pin_raw),
    .q       (pin_s)
  );

  spp_edge u_sck_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .lvl     (pin_s.sck),
    .rise    (sck_rise),
    .fall    (sck_fall)
  );

  spp_edge u_frm_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .lvl     (pin_s.frm),
    .rise    (frm_rise),
    .fall    ()
  );

  function automatic logic hit(input logic [7:0] ofs);
    hit = (paddr == ofs);
  endfunction

  logic wr_acc;
  logic rd_acc;
  logic on;
  logic framed;
  logic slave;
  logic [1:0] txsel;
  logic [2:0] fcnt;
  logic frame_clash;
  logic tur_clr;
  logic underrun;
  logic last_bit;

  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign on      = serial_port_control_reg[CTRL_ON_BIT];
  assign framed  = serial_port_control_reg[CTRL_FRAME_BIT];
  assign slave   = serial_port_control_reg[CTRL_SLAVE_BIT];
  assign txsel   = serial_port_control_reg[CTRL_TXSEL_LSB +: 2];
  assign fcnt    = serial_port_control_reg[CTRL_FCNT_LSB +: 3];
  // Frame pulse arriving together with a clock edge
  assign frame_clash = framed & slave & (fcnt != 3'h0)
                       & frm_rise & sck_fall; // RL10
  assign last_bit = (bitcnt_r == BITCNT_LAST);
  assign underrun = on & (state_r == ST_IDLE) & sck_fall & ~tx_loaded_r
                    & slave;

  // Software clear of underrun flag: full word, or byte 0 mirrored to byte 1
  assign tur_clr = wr_acc & hit(STAT_OFS) & serial_port_status_reg[STAT_TUR_BIT]
                   & (((pstrb == 4'hf) & ~pwdata[STAT_TUR_BIT])
                      | ((pstrb == 4'h1) & ~pwdata[0]));

  always_comb
  begin
    pslverr = 1'b0;
    if (psel & penable)
      pslverr = ~(hit(CTRL_OFS) | hit(STAT_OFS) | hit(TXBUF_OFS)
                  | hit(RXBUF_OFS) | hit(IRQ_STAT_OFS)
                  | hit(IRQ_MASK_OFS) | hit(SLEEP_OFS));
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      serial_port_control_reg <= CTRL_RESET;
    else
    begin
      logic [31:0] c;
      c = serial_port_control_reg;
      if (wr_acc & hit(CTRL_OFS) & (state_r != ST_RECOVER))
        c = (c & ~CTRL_RW_MASK) | (pwdata & CTRL_RW_MASK);
      // Busy and shift-empty flip half a bit time early, on the last falling edge
      c[CTRL_MBUSY_BIT] = (state_r == ST_SHIFT) & ~last_bit; // RL9
      c[CTRL_SHIFT_REG_EMPTY_FLAG_BIT]  = ~((state_r == ST_SHIFT) & ~last_bit); // RL9
      serial_port_control_reg <= c;
    end

  // Status register with the faulty byte lane decode
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      serial_port_status_reg <= STAT_RESET;
    else
    begin
      logic [31:0] s;
      s = serial_port_status_reg;
      if (wr_acc & hit(STAT_OFS))
      begin
        if (pstrb == 4'hf)
          s[STAT_TUR_BIT] = s[STAT_TUR_BIT] & pwdata[STAT_TUR_BIT];
        else if (pstrb == 4'h1)
        begin
          s[15:8] = pwdata[7:0]; // RL4
          s[7:0]  = pwdata[7:0]; // RL4
        end
        // pstrb 4'h2 alone leaves the register as it was // RL5
      end
      if (underrun)
        s[STAT_TUR_BIT] = 1'b1;
      if (xfer_done_r & serial_port_status_reg[STAT_RBF_BIT])
        s[STAT_ROV_BIT] = 1'b1;
      if (xfer_done_r)
        s[STAT_RBF_BIT] = 1'b1;
      else if (rd_acc & hit(RXBUF_OFS))
        s[STAT_RBF_BIT] = 1'b0;
      s[STAT_TBE_BIT] = ~tx_loaded_r;
      serial_port_status_reg <= s;
    end

  // Serial engine; recovery holds off the engine after underrun clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state_r     <= ST_IDLE;
      shift_r     <= 8'h00;
      rcv_r       <= 8'h00;
      bitcnt_r    <= 3'h0;
      wait_r      <= 8'h00;
      tx_loaded_r <= 1'b0;
      xfer_done_r <= 1'b0;
      txbuf_r     <= 32'h0000_0000;
      rxbuf_r     <= 32'h0000_0000;
    end
    else
    begin
      xfer_done_r <= 1'b0;
      if (wr_acc & hit(TXBUF_OFS) & (state_r != ST_RECOVER))
      begin
        txbuf_r     <= pwdata;
        tx_loaded_r <= 1'b1;
      end
      unique case (state_r)
        ST_IDLE:
          if (tur_clr & framed)
          begin
            state_r <= ST_RECOVER; // RL7
            wait_r  <= RECOVER_CYC; // RL8
          end
          else if (on & sck_fall & tx_loaded_r)
          begin
            shift_r     <= txbuf_r[7:0] ^ {frame_clash, 7'h00}; // RL10
            tx_loaded_r <= 1'b0;
            bitcnt_r    <= 3'h0;
            state_r     <= ST_SHIFT;
          end
        ST_SHIFT:
        begin
          if (sck_rise)
            rcv_r <= {rcv_r[6:0], pin_s.sdi};
          // Last rising edge samples the final bit and ends the byte
          if (sck_rise & last_bit)
          begin
            state_r     <= ST_IDLE;
            rxbuf_r     <= {24'h0, rcv_r[6:0], pin_s.sdi};
            xfer_done_r <= 1'b1;
          end
          if (sck_fall)
          begin
            // Clash shifts a one into the low bit
            shift_r  <= {shift_r[6:0], frame_clash}; // RL10
            bitcnt_r <= bitcnt_r + 3'h1;
          end
        end
        ST_RECOVER:
          if (wait_r == 8'h00)
            state_r <= ST_IDLE;
          else
            wait_r <= wait_r - 8'h01;
      endcase
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sdo_out <= 1'b0;
    else
      sdo_out <= shift_r[7] ^ ((state_r == ST_SHIFT) & frame_clash);

  // Sleep control and spurious wake on sleep entry
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sleep_r      <= 1'b0;
      sleep_prev_r <= 1'b0;
    end
    else
    begin
      if (wr_acc & hit(SLEEP_OFS))
        sleep_r <= pwdata[0];
      sleep_prev_r <= sleep_r;
    end

  always_comb
  begin
    ev = '0;
    ev[IRQ_TX_BIT]  = xfer_done_r
                      | (underrun & (txsel != TXSEL_UNDERRUN_BLIND)); // RL1
    ev[IRQ_RX_BIT]  = xfer_done_r;
    ev[IRQ_TUR_BIT] = underrun;
    ev[IRQ_WAKE_BIT] = slave & sleep_r & ~sleep_prev_r
                       & (irq_mask_r != '0); // RL3
  end

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq_stat_r <= IRQ_RESET;
    else if (wr_acc & hit(IRQ_STAT_OFS))
      irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | ev;
    else
      irq_stat_r <= irq_stat_r | ev;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq_mask_r <= IRQ_RESET;
    else if (wr_acc & hit(IRQ_MASK_OFS))
      irq_mask_r <= pwdata[IRQ_W-1:0];

  assign irq = |(irq_stat_r & irq_mask_r);

  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_acc)
      unique case (1'b1)
        hit(CTRL_OFS):     prdata = serial_port_control_reg;
        hit(STAT_OFS):     prdata = serial_port_status_reg;
        hit(TXBUF_OFS):    prdata = txbuf_r;
        hit(RXBUF_OFS):    prdata = rxbuf_r;
        hit(IRQ_STAT_OFS): prdata = {28'h0, irq_stat_r};
        hit(IRQ_MASK_OFS): prdata = {28'h0, irq_mask_r};
        hit(SLEEP_OFS):    prdata = {31'h0, sleep_r};
        default:           prdata = 32'h0000_0000;
      endcase
  end
endmodule // serial_peripheral_port

// [tb/spp_chk.sv]
// Pin-level assertions for the serial peripheral port.
// Assumes binding into serial_peripheral_port, pready tied high.
`timescale 1ns/1ps
module spp_chk
  import spp_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  logic       acc;
  logic       wr;
  logic [3:0] mask_r;
  logic       slave_r;
  logic       sleep_r;
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0];
  // Shadows of mask, mode and sleep request
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mask_r <= 4'h0;
      slave_r <= 1'b0;
      sleep_r <= 1'b0;
    end
    else if (wr && paddr == IRQ_MASK_OFS)
      mask_r <= pwdata[3:0];
    else if (wr && paddr == CTRL_OFS)
      slave_r <= pwdata[CTRL_SLAVE_BIT];
    else if (wr && paddr == SLEEP_OFS)
      sleep_r <= pwdata[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err_idle; pslverr |-> acc; endproperty
  a_err_idle: assert property (p_err_idle) else $error("stray error");
  property p_err_unmap; acc && paddr > SLEEP_OFS |-> pslverr; endproperty
  a_err_unmap: assert property (p_err_unmap) else $error("no error");
  property p_stat_ok; acc && paddr == STAT_OFS |-> !pslverr; endproperty
  a_stat_ok: assert property (p_stat_ok) else $error("status error");
  property p_mask_off;
    wr && paddr == IRQ_MASK_OFS && pwdata[3:0] == 4'h0 |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq unmasked");
  property p_masked; irq |-> mask_r != 4'h0 || $past(mask_r) != 4'h0;
  endproperty
  a_masked: assert property (p_masked) else $error("irq with no mask");
  property p_wake;
    wr && paddr == SLEEP_OFS && pwdata[0] && !sleep_r && slave_r &&
      mask_r[IRQ_WAKE_BIT] |-> ##[1:2] irq;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake irq");
  property p_start; $rose(presetn) |-> !irq ##1 !irq; endproperty
  a_start: assert property (p_start) else $error("irq after reset");
endmodule // spp_chk
bind serial_peripheral_port spp_chk u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .irq);

// [tb/spp_link_master.sv]
// Behavioural external serial master driving the link pins.
// Assumes 125 ns bit time, clock idle high, data set on falling edge.
`timescale 1ns/1ps
module spp_link_master
(
  output logic      sck,
  output logic      frm,
  output logic      sdi,
  input  wire logic sdo
);
  logic active;
  initial
  begin
    sck = 1'b1;
    frm = 1'b0;
    sdi = 1'b0;
    active = 1'b0;
  end
  // One byte MSB first; frame ahead of clock unless a clash is asked
  task automatic xfer(input logic [7:0] d, input logic clash,
                      output logic [7:0] q);
    active = 1'b1;
    frm = 1'b1;
    if (!clash)
      #62.5;
    for (int i = 7; i >= 0; i--)
    begin
      sck = 1'b0;
      sdi = d[i];
      #62.5;
      frm = 1'b0;
      sck = 1'b1;
      q[i] = sdo;
      #62.5;
    end
    sdi = ~sdi;
    active = 1'b0;
  endtask
endmodule // spp_link_master

// [tb/tb_serial_peripheral_port.sv]
// Testbench for the serial peripheral port.
// Assumes the link master model and the bound checker.
`timescale 1ns/1ps
module tb_serial_peripheral_port;
  import spp_pkg::*;
  localparam logic [31:0] CSL = 32'h0000_8020;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        sck_in, frm_in, sdi_in, sdo_out, irq, e;
  logic [7:0]  paddr, q;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  int          error_cnt, tests_run;
  serial_peripheral_port uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sck_in, .frm_in,
    .sdi_in, .sdo_out, .irq);
  spp_link_master ext (.sck(sck_in), .frm(frm_in), .sdi(sdi_in),
    .sdo(sdo_out));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic stop_test();
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, s, x);
    end
  endtask
  // One transfer; answer taken at the edge where pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
      begin
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        return;
      end
    end
    error_cnt++;
    stop_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    for (int n = 0; n < 100; n++)
    begin
      rd(a);
      if (r[b] === v)
        return;
    end
    error_cnt++;
    stop_test();
  endtask
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    error_cnt = 0;
    tests_run = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTRL_OFS);
    chk(r, CTRL_RESET);
    rd(STAT_OFS);
    chk(r, STAT_RESET);
    rd(8'h1c);
    chk(32'(e), 32'h1);
    // Plain byte both ways, busy watched near the end
    wr(CTRL_OFS, CSL | 32'h4);
    wr(TXBUF_OFS, 32'h0000_00a5);
    fork
      ext.xfer(8'h3c, 1'b0, q);
      begin
        wait_bit(CTRL_OFS, CTRL_MBUSY_BIT, 1'b1);
        wait_bit(CTRL_OFS, CTRL_MBUSY_BIT, 1'b0);
        chk(32'(ext.active), 32'h1);
        chk(32'(r[CTRL_SHIFT_REG_EMPTY_FLAG_BIT]), 32'h1);
      end
    join
    chk(32'(q), 32'h0000_00a5);
    rd(RXBUF_OFS);
    chk(r & 32'hff, 32'h0000_003c);
    // Wake on sleep entry, cleared, then raised again
    wr(IRQ_MASK_OFS, 32'h0000_0008);
    for (int k = 0; k < 2; k++)
    begin
      wr(SLEEP_OFS, 32'h0);
      wr(SLEEP_OFS, 32'h1);
      repeat (2) @(negedge pclk);
      chk(32'(irq), 32'h1);
      wr(IRQ_STAT_OFS, 32'h0000_0008);
      @(negedge pclk);
      chk(32'(irq), 32'h0);
    end
    wr(IRQ_MASK_OFS, 32'h0);
    // Underrun under each transmit interrupt selection
    for (int s = 0; s < 4; s++)
    begin
      wr(CTRL_OFS, CSL | 32'(s << CTRL_TXSEL_LSB));
      wr(IRQ_STAT_OFS, 32'h0000_000f);
      ext.xfer(8'h00, 1'b0, q);
      rd(IRQ_STAT_OFS);
      chk(32'(r[IRQ_TX_BIT]), 32'(s != 0));
      chk(32'(r[IRQ_TUR_BIT]), 32'h1);
      wr(STAT_OFS, 32'h0);
    end
    // Framed underrun, byte lanes, then refusal during recovery
    wr(CTRL_OFS, CSL | 32'h8000_0000);
    ext.xfer(8'h00, 1'b0, q);
    apb(1'b1, STAT_OFS, 32'h0, 4'h2);
    rd(STAT_OFS);
    chk(32'(r[STAT_TUR_BIT]), 32'h1);
    apb(1'b1, STAT_OFS, 32'h0, 4'h1);
    rd(STAT_OFS);
    chk(32'(r[STAT_TUR_BIT]), 32'h0);
    wr(TXBUF_OFS, 32'h0000_00c3);
    rd(STAT_OFS);
    chk(32'(r[STAT_TBE_BIT]), 32'h1);
    repeat (60) @(posedge pclk);
    wr(TXBUF_OFS, 32'h0000_005a);
    ext.xfer(8'h00, 1'b0, q);
    chk(32'(q), 32'h0000_005a);
    // Frame pulse on the clock edge with a nonzero frame count
    wr(CTRL_OFS, CSL | 32'h8100_0000);
    wr(TXBUF_OFS, 32'h0000_005a);
    ext.xfer(8'h00, 1'b1, q);
    chk(32'(q == 8'h5a), 32'h0);
    stop_test();
  end
endmodule // tb_serial_peripheral_port
